// ---- inc/twbh_pkg.sv ----
// Constants and types shared by the two-wire byte handshake block.
package twbh_pkg;
   // Register byte offsets on the APB slave.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_RATE = 8'h0c;
   // Control register bit positions.
   localparam int CTL_FLAG = 7;
   localparam int CTL_START = 5;
   localparam int CTL_STOP = 4;
   localparam int CTL_EN = 2;
   localparam int CTL_IE = 0;
   // Status codes.
   localparam logic [7:0] ST_START = 8'h08;
   localparam logic [7:0] ST_RSTART = 8'h10;
   localparam logic [7:0] ST_ADDR_ACK = 8'h18;
   localparam logic [7:0] ST_ADDR_NACK = 8'h20;
   localparam logic [7:0] ST_DATA_ACK = 8'h28;
   localparam logic [7:0] ST_DATA_NACK = 8'h30;
   localparam logic [7:0] ST_NONE = 8'hf8;
   // Reset values.
   localparam logic [7:0] DATA_RST = 8'hff;
   localparam logic [7:0] RATE_RST = 8'h7c;
   // Bit slot index of the acknowledge bit.
   localparam logic [3:0] ACK_SLOT = 4'h8;
   // Sequencer states.
   typedef enum logic [2:0] {S_IDLE, S_START, S_SHIFT, S_STOP, S_WAIT} twbh_state_t;
endpackage

// ---- logic/twbh_sync.sv ----
// Two-flop synchroniser for the bus line inputs.
`timescale 1ns/100ps
`default_nettype none
module twbh_sync #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } twbh_sync_t;
   twbh_sync_t s;
   twbh_sync_t next_s;

   // The first stage feeds only the second stage.
   always_comb begin
      next_s.meta = async_in;
      next_s.sync = s.meta;
   end

   // Lines idle high, so both stages reset to one.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '1;
      end else begin
         s <= next_s;
      end
   end

   assign sync_out = s.sync;
endmodule
`default_nettype wire

// ---- logic/twbh_core.sv ----
// Two-wire byte handshake controller with an APB register slave.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module twbh_core
   import twbh_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_global_ie,
   output logic irq,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   generate
      if (ADDR_W < 4 || ADDR_W > 32) begin : g_bad_addr
         $error("twbh_core: ADDR_W must lie between 4 and 32");
      end
   endgenerate

   typedef struct packed {
      twbh_state_t st;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic flag;
      logic ie;
      logic en;
      logic on_bus;
      logic is_addr;
      logic [7:0] code;
      logic [7:0] status;
      logic [7:0] shreg;
      logic [7:0] rate;
      logic [7:0] div;
      logic tick;
      logic scl_oe;
      logic sda_oe;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } twbh_regs_t;

   twbh_regs_t s;
   twbh_regs_t next_s;
   logic [1:0] lines;
   logic scl_s;
   logic sda_s;
   logic acc;
   logic wr;
   logic wr_ctrl;
   logic [7:0] addr8;
   logic adv;
   logic en_new;
   logic go;

   // Pins come from outside the clock domain and pass two flops first.
   twbh_sync #(.W(2)) i_twbh_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({scl_in, sda_in}),
      .sync_out(lines)
   );
   assign scl_s = lines[1];
   assign sda_s = lines[0];

   // Bus decode; a write lands on the edge where pready is seen high.
   assign addr8 = 8'(paddr);
   assign acc = psel & penable;
   assign wr = acc & s.pready & pwrite;
   assign wr_ctrl = wr & (addr8 == ADDR_CTRL);
   assign en_new = pwdata[CTL_EN];
   // A step waits while the clock is released but still low, so a slave may stretch it.
   assign adv = s.tick & (s.scl_oe | scl_s);

   // Whole next-state computation.
   always_comb begin
      next_s = s;
      go = 1'b0;
      // Quarter-bit divider; the rate register sets the bus speed.
      next_s.tick = (s.div == 8'h00);
      next_s.div = (s.div == 8'h00) ? s.rate : s.div - 8'h01;
      // Interrupt only with both enables, registered so the pin is glitch free.
      next_s.irq = s.flag & s.ie & cpu_global_ie;
      // Status trails the flag by one cycle, and idles at the no-info code.
      next_s.status = s.flag ? s.code : ST_NONE;

      // Bit-level sequencer, four quarter phases per step.
      if (adv && s.st != S_IDLE && s.st != S_WAIT) begin
         next_s.ph = s.ph + 2'h1;
         case (s.st)
            S_START: begin
               case (s.ph)
                  2'h0: begin
                     next_s.scl_oe = 1'b1;
                     next_s.sda_oe = 1'b0;
                  end
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2: next_s.sda_oe = 1'b1;
                  default: begin
                     // START done: hold the clock and report it.
                     next_s.scl_oe = 1'b1;
                     next_s.flag = 1'b1;
                     next_s.code = s.on_bus ? ST_RSTART : ST_START;
                     next_s.on_bus = 1'b1;
                     next_s.is_addr = 1'b1;
                     next_s.st = S_WAIT;
                  end
               endcase
            end
            S_SHIFT: begin
               case (s.ph)
                  2'h0: begin
                     next_s.scl_oe = 1'b1;
                     // Open drain: drive low for a zero, release for a one and for the ack slot.
                     next_s.sda_oe = (s.bitn == ACK_SLOT) ? 1'b0 : ~s.shreg[7];
                  end
                  2'h1: next_s.scl_oe = 1'b1;
                  2'h2: next_s.scl_oe = 1'b0;
                  default: begin
                     next_s.scl_oe = 1'b1;
                     if (s.bitn == ACK_SLOT) begin
                        next_s.flag = 1'b1;
                        next_s.st = S_WAIT;
                        next_s.is_addr = 1'b0;
                        next_s.sda_oe = 1'b0;
                        if (s.is_addr) begin
                           next_s.code = sda_s ? ST_ADDR_NACK : ST_ADDR_ACK;
                        end else begin
                           next_s.code = sda_s ? ST_DATA_NACK : ST_DATA_ACK;
                        end
                     end else begin
                        // The same register shifts out address and data bytes.
                        next_s.shreg = {s.shreg[6:0], sda_s};
                        next_s.bitn = s.bitn + 4'h1;
                     end
                  end
               endcase
            end
            S_STOP: begin
               case (s.ph)
                  2'h0: begin
                     next_s.scl_oe = 1'b1;
                     next_s.sda_oe = 1'b1;
                  end
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2: next_s.sda_oe = 1'b0;
                  default: begin
                     // Both lines released, no flag after a STOP.
                     next_s.st = S_IDLE;
                     next_s.on_bus = 1'b0;
                  end
               endcase
            end
            default: next_s.st = S_IDLE;
         endcase
      end

      // The clock stays pulled low for as long as the flag is up.
      if (s.st == S_WAIT) begin
         next_s.scl_oe = 1'b1;
      end

      // APB answer one cycle into the access phase.
      next_s.pready = acc & ~s.pready;
      next_s.pslverr = 1'b0;
      next_s.prdata = 32'h0000_0000;
      if (acc && !s.pready) begin
         case (addr8)
            ADDR_CTRL: next_s.prdata = {24'h00_0000, s.flag, 4'h0, s.en, 1'b0, s.ie};
            ADDR_STAT: next_s.prdata = {24'h00_0000, s.status};
            ADDR_DATA: next_s.prdata = {24'h00_0000, s.shreg};
            ADDR_RATE: next_s.prdata = {24'h00_0000, s.rate};
            default: next_s.pslverr = 1'b1;
         endcase
      end

      // Register writes take precedence over the sequencer in the same cycle.
      if (wr) begin
         case (addr8)
            ADDR_CTRL: begin
               next_s.ie = pwdata[CTL_IE];
               next_s.en = en_new;
               // With en_new set, clearing needs a one; a zero leaves the flag untouched.
               if (pwdata[CTL_FLAG] && s.flag) begin
                  next_s.flag = 1'b0;
               end
               // Nothing launches while the flag stays set.
               go = s.flag ? pwdata[CTL_FLAG] : (s.st == S_IDLE);
               if (go && en_new) begin
                  next_s.ph = 2'h0;
                  // The written value picks the next operation.
                  if (pwdata[CTL_START]) begin
                     next_s.st = S_START;
                  end else if (pwdata[CTL_STOP] && s.st == S_WAIT) begin
                     next_s.st = S_STOP;
                  end else if (s.st == S_WAIT) begin
                     next_s.st = S_SHIFT;
                     next_s.bitn = 4'h0;
                  end
               end
               // Disabling abandons the bus and lets both lines go.
               if (!en_new) begin
                  next_s.st = S_IDLE;
                  next_s.flag = 1'b0;
                  next_s.on_bus = 1'b0;
                  next_s.scl_oe = 1'b0;
                  next_s.sda_oe = 1'b0;
               end
            end
            ADDR_DATA: begin
               // Loading mid-byte would corrupt the shift, so only idle or waiting accepts it.
               if (s.st == S_IDLE || s.st == S_WAIT) begin
                  next_s.shreg = pwdata[7:0];
               end
            end
            ADDR_RATE: next_s.rate = pwdata[7:0];
            default: next_s.rate = s.rate;
         endcase
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
         s.st <= S_IDLE;
         s.code <= ST_NONE;
         s.status <= ST_NONE;
         s.shreg <= DATA_RST;
         s.rate <= RATE_RST;
         s.div <= RATE_RST;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register; drive value is always low.
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign irq = s.irq;
   assign scl_oe = s.scl_oe;
   assign sda_oe = s.sda_oe;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;

   // Checks on the handshake.
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_stat_follow: assert property ($rose(s.flag) |=> s.status == $past(s.code))
      else $error("status did not follow the flag by one cycle");
   chk_stat_none: assert property (!s.flag |=> s.status == ST_NONE)
      else $error("status not at no-info code while flag clear");
   chk_scl_hold: assert property (s.flag |-> s.scl_oe)
      else $error("clock released while flag set");
   chk_flag_blocks: assert property (s.flag && !wr_ctrl |=> s.st == S_WAIT)
      else $error("operation started while flag set");
   chk_flag_clear: assert property (wr_ctrl && pwdata[CTL_FLAG] && s.flag |=> !s.flag)
      else $error("flag not cleared by writing one");
   chk_start_go: assert property (wr_ctrl && s.flag && pwdata[CTL_FLAG] && pwdata[CTL_START]
      && en_new |=> s.st == S_START && !s.flag)
      else $error("start did not begin after clearing write");
   chk_start_code: assert property (s.st == S_START && next_s.st == S_WAIT
      |=> s.flag && (s.code == ST_START || s.code == ST_RSTART))
      else $error("start completion without flag or code");
   chk_ack_code: assert property (s.st == S_SHIFT && next_s.st == S_WAIT
      |=> s.flag && s.code == ($past(s.is_addr) ? ($past(sda_s) ? ST_ADDR_NACK : ST_ADDR_ACK)
      : ($past(sda_s) ? ST_DATA_NACK : ST_DATA_ACK))
      ##1 s.status == $past(s.code))
      else $error("byte completion without ack status");
   chk_stop_idle: assert property (s.st == S_STOP && next_s.st == S_IDLE
      |=> !s.flag && !s.scl_oe && !s.sda_oe)
      else $error("stop left a flag or a driven line");
   chk_irq_gate: assert property (1'b1 |=> s.irq == $past(s.flag && s.ie && cpu_global_ie))
      else $error("interrupt not gated by both enables");
   // The flag may only stand in the wait state, and software must find the event code there.
   chk_flag_wait: assert property (s.flag |-> s.st == S_WAIT)
      else $error("flag set outside the wait state");
   chk_stat_hold: assert property (s.flag && $past(s.flag) |-> s.status == s.code)
      else $error("status lost the event code while flag set");
   chk_idle_lines: assert property (s.st == S_IDLE |-> !s.scl_oe && !s.sda_oe)
      else $error("line driven while idle");
   chk_stop_noflag: assert property (s.st == S_STOP |=> !s.flag)
      else $error("flag raised during a stop");
   chk_ack_release: assert property (s.st == S_SHIFT && s.bitn == ACK_SLOT && s.ph != 2'h0 |-> !s.sda_oe)
      else $error("data line driven in the acknowledge slot");
   chk_data_load: assert property (wr && addr8 == ADDR_DATA && (s.st == S_IDLE || s.st == S_WAIT)
      |=> s.shreg == $past(pwdata[7:0]))
      else $error("shift register not loaded by a data write");
   chk_send_go: assert property (wr_ctrl && s.flag && pwdata[CTL_FLAG] && !pwdata[CTL_START]
      && !pwdata[CTL_STOP] && en_new |=> s.st == S_SHIFT && s.bitn == 4'h0)
      else $error("byte did not start after clearing write");
   chk_stop_go: assert property (wr_ctrl && s.flag && pwdata[CTL_FLAG] && !pwdata[CTL_START]
      && pwdata[CTL_STOP] && en_new |=> s.st == S_STOP)
      else $error("stop did not begin after clearing write");

   // Scenario covers: START, acknowledged data, refused address and STOP.
   cov_start: cover property (s.st == S_START ##[1:600] s.flag && s.code == ST_START);
   cov_data_ack: cover property (s.flag && s.code == ST_DATA_ACK);
   cov_addr_nack: cover property (s.flag && s.code == ST_ADDR_NACK);
   cov_stop: cover property (s.st == S_STOP ##[1:600] s.st == S_IDLE);
endmodule
`default_nettype wire

// ---- sim/twbh_slave.sv ----
// Behavioural two-wire target that takes bytes, acknowledges them and can stretch the clock.
`timescale 1ns/100ps
`default_nettype none
module twbh_slave (
   input wire logic scl,
   input wire logic sda,
   input wire logic nack,
   input wire logic slow,
   output logic scl_pull,
   output logic sda_pull,
   output logic [7:0] last_byte,
   output logic got_stop
);
   int bit_cnt;
   logic [7:0] shift;
   // Released lines float high through the pull-up, so the model only ever pulls low.
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
      last_byte = 8'h00;
      got_stop = 1'b0;
      bit_cnt = 0;
      shift = 8'h00;
   end
   // A falling data line while the clock is high marks a start, a rising one a stop.
   always @(negedge sda) begin
      if (scl === 1'b1) begin
         bit_cnt = 0;
         got_stop = 1'b0;
      end
   end
   always @(posedge sda) begin
      if (scl === 1'b1) begin
         got_stop = 1'b1;
      end
   end
   // Bits are taken on the rising clock, most significant first.
   always @(posedge scl) begin
      if (bit_cnt < 8) begin
         shift = {shift[6:0], sda};
         bit_cnt++;
      end
   end
   // The acknowledge slot is driven from one falling clock to the next; a slow target also holds the clock low.
   always @(negedge scl) begin
      if (bit_cnt == 8) begin
         bit_cnt = 9;
         sda_pull = ~nack;
         last_byte = shift;
         if (slow) begin
            scl_pull = 1'b1;
            #200;
            scl_pull = 1'b0;
         end
      end else if (bit_cnt == 9) begin
         bit_cnt = 0;
         sda_pull = 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- sim/twbh_core_tb.sv ----
// Self-checking bench for the two-wire byte handshake controller.
`timescale 1ns/100ps
`default_nettype none
module twbh_core_tb
   import twbh_pkg::*;
;
   localparam logic [31:0] C_FL = 32'h1 << CTL_FLAG;
   localparam logic [31:0] C_ST = 32'h1 << CTL_START;
   localparam logic [31:0] C_SP = 32'h1 << CTL_STOP;
   localparam logic [31:0] C_ON = (32'h1 << CTL_EN) | (32'h1 << CTL_IE);
   localparam logic [31:0] C_EN = 32'h1 << CTL_EN;
   logic pclk, presetn, psel, penable, pwrite, cpu_global_ie, nack, slow, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, irq, scl_oe, sda_oe, s_scl, s_sda, got_stop, scl_w, sda_w, scl_o, sda_o;
   logic [7:0] last_byte;
   int n_mismatch, check_count;
   // Open-drain bus: an enabled controller drives its output level, the target only pulls low.
   assign scl_w = (scl_oe ? scl_o : 1'b1) & ~s_scl;
   assign sda_w = (sda_oe ? sda_o : 1'b1) & ~s_sda;
   twbh_core #(.ADDR_W(8)) i_twbh_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_global_ie(cpu_global_ie), .irq(irq), .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe));
   twbh_slave i_twbh_slave (.scl(scl_w), .sda(sda_w), .nack(nack), .slow(slow), .scl_pull(s_scl),
      .sda_pull(s_sda), .last_byte(last_byte), .got_stop(got_stop));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request is held until pready is seen at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Software polls the flag to learn that an event is over, rather than waiting for irq.
   task automatic wait_flag();
      int n;
      for (n = 0; n < 300; n++) begin
         apb(1'b0, ADDR_CTRL, 32'h0);
         if (rd[CTL_FLAG] === 1'b1) break;
      end
      if (rd[CTL_FLAG] !== 1'b1) begin
         n_mismatch++;
         finish_test();
      end
   endtask
   task automatic t_reset();
      rchk(ADDR_STAT, {24'h0, ST_NONE});
      rchk(ADDR_DATA, {24'h0, DATA_RST});
      rchk(ADDR_RATE, {24'h0, RATE_RST});
      rchk(ADDR_CTRL, 32'h0);
      apb(1'b1, 8'h10, 32'h0000_00ff);
      chk({31'h0, err}, 32'h1);
      // A quarter of four cycles gives the 80 ns bus clock.
      apb(1'b1, ADDR_RATE, 32'h3);
      rchk(ADDR_RATE, 32'h3);
      chk({30'h0, scl_oe, sda_oe}, 32'h0);
   endtask
   // START, address, data and repeated start, then STOP.
   task automatic run_write(input logic [7:0] addr, input logic [7:0] data, input logic use_nack,
      input logic use_slow);
      logic o;
      int n;
      nack <= use_nack;
      slow <= use_slow;
      apb(1'b1, ADDR_CTRL, C_ST | C_ON);
      wait_flag();
      rchk(ADDR_STAT, {24'h0, ST_START});
      chk({31'h0, scl_oe}, 32'h1);
      apb(1'b1, ADDR_CTRL, C_ON);
      o = sda_oe;
      repeat (20) @(posedge pclk);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk({31'h0, rd[CTL_FLAG]}, 32'h1);
      chk({31'h0, sda_oe}, {31'h0, o});
      apb(1'b1, ADDR_DATA, {24'h0, addr});
      apb(1'b1, ADDR_CTRL, C_FL | C_ON);
      wait_flag();
      rchk(ADDR_STAT, {24'h0, use_nack ? ST_ADDR_NACK : ST_ADDR_ACK});
      chk({24'h0, last_byte}, {24'h0, addr});
      rchk(ADDR_DATA, {24'h0, addr});
      cpu_global_ie <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      cpu_global_ie <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      // Dropping only the interrupt enable must silence the request as well.
      apb(1'b1, ADDR_CTRL, C_EN);
      repeat (3) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, ADDR_CTRL, C_ON);
      // The data byte goes out after a refused address too, so both data codes are seen.
      apb(1'b1, ADDR_DATA, {24'h0, data});
      apb(1'b1, ADDR_CTRL, C_FL | C_ON);
      wait_flag();
      rchk(ADDR_STAT, {24'h0, use_nack ? ST_DATA_NACK : ST_DATA_ACK});
      chk({24'h0, last_byte}, {24'h0, data});
      rchk(ADDR_DATA, {24'h0, data});
      apb(1'b1, ADDR_CTRL, C_FL | C_ST | C_ON);
      wait_flag();
      rchk(ADDR_STAT, {24'h0, ST_RSTART});
      apb(1'b1, ADDR_CTRL, C_FL | C_SP | C_ON);
      n = 0;
      while (n < 500 && !(got_stop === 1'b1 && scl_oe === 1'b0 && sda_oe === 1'b0)) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 500) begin
         n_mismatch++;
         finish_test();
      end
      chk({30'h0, scl_oe, sda_oe}, 32'h0);
      chk({31'h0, got_stop}, 32'h1);
      repeat (60) @(posedge pclk);
      rchk(ADDR_CTRL, C_ON);
      rchk(ADDR_STAT, {24'h0, ST_NONE});
   endtask
   // Turning the unit off while it holds the bus abandons the bus and drops the flag.
   task automatic t_abort();
      apb(1'b1, ADDR_CTRL, C_ST | C_ON);
      wait_flag();
      rchk(ADDR_STAT, {24'h0, ST_START});
      apb(1'b1, ADDR_CTRL, 32'h0);
      rchk(ADDR_CTRL, 32'h0);
      chk({30'h0, scl_oe, sda_oe}, 32'h0);
      rchk(ADDR_STAT, {24'h0, ST_NONE});
   endtask
   // Main sequence: reset held for 20 cycles, then the scenarios in turn.
   initial begin
      n_mismatch = 0;
      check_count = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cpu_global_ie = 1'b1;
      nack = 1'b0;
      slow = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      run_write(8'ha4, 8'h5a, 1'b0, 1'b0);
      run_write(8'h3c, 8'hc3, 1'b1, 1'b1);
      t_abort();
      finish_test();
   end
endmodule
`default_nettype wire
